// ### core/wdr_watchdog.sv
/*
  Watchdog timeout reset: unlock sequencer, prescaled machine-cycle counter
  (base and programmable stages), reset pulse generator, Avalon-MM slave and
  interrupt status. Assumes clk is the oscillator, power_down comes from core
  logic on clk, and ext_wake_int_n is an asynchronous pin.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
// How it works
// - After any reset the watchdog is disabled and neither counts nor fires.
// - Only a write of 1EH directly followed by a write of E1H to the restart register arms it.
// - While enabled the count steps once per machine cycle, except in power-down and in the post-wake hold.
// - Once enabled it stays enabled until a hardware reset or its own overflow.
// - An overflow drives a reset pulse lasting 96 oscillator periods.
// - While enabled, writes to the duration selection are ignored.
// - The counter is a 14-bit base stage feeding a 7-bit programmable stage.
// - A selection S sets the timeout to 2^(14+S)-1 machine cycles.
// - A machine cycle is 6 oscillator periods, doubled when both double-speed bits are set.
// - The duration selection resets to zero, the shortest timeout.
// - In power-down the count stops and holds, so no timeout can fire.
// - After a wake by the external interrupt, counting waits until that pin is high again.
`timescale 1ns/100ps
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int BASE_W = 14,
  parameter int PROG_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core power state and wake pin
  input wire logic power_down,
  input wire logic ext_wake_int_n,
  // Reset pulse out and interrupt
  output logic wdt_reset_pulse,
  output logic irq
);
  localparam int CNT_W = BASE_W + PROG_W;

  initial begin
    // Selection 7 needs seven programmable bits; the count is read back in one word
    if (BASE_W < 1 || PROG_W < 7 || BASE_W + PROG_W > 32) begin
      $error("wdr_watchdog: unsupported counter widths");
    end
  end

  logic ack_q;
  logic [31:0] rdata_q;
  logic pend_q;
  logic en_q;
  logic [BASE_W-1:0] base_q;
  logic [PROG_W-1:0] prog_q;
  logic [3:0] pre_q;
  logic [6:0] pulse_q;
  logic wake_hold_q;
  logic sync1_q;
  logic sync2_q;
  logic [WDR_EV_W-1:0] status_q;
  logic [WDR_EV_W-1:0] mask_q;
  wdr_cfg_s cfg_q;
  wdr_state_s state;

  logic req;
  logic acc;
  logic wr_lo;
  logic first_hit;
  logic arm;
  logic abort;
  logic tick;
  logic hold;
  logic ovf;
  logic [3:0] mc_div;
  logic [PROG_W-1:0] prog_lim;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;

  // One wait state: the answer is ready at the second edge of a request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign acc = req & ack_q;
  assign wr_lo = acc & avs_write & avs_byteenable[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Unlock sequencer: any other accepted transfer between the bytes breaks it
  assign first_hit = wr_lo && avs_address == WDR_IDX_RESTART
                     && avs_writedata[7:0] == WDR_UNLOCK_FIRST;
  assign arm = pend_q && wr_lo && avs_address == WDR_IDX_RESTART
               && avs_writedata[7:0] == WDR_UNLOCK_SECOND;
  assign abort = pend_q && acc && !arm && !first_hit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (acc) begin
      pend_q <= first_hit && !pend_q ? 1'b1 : first_hit;
    end
  end

  // Enable: set by the pair, cleared only by overflow or reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else if (ovf) begin
      en_q <= 1'b0;
    end else if (arm) begin
      en_q <= 1'b1;
    end
  end

  // Configuration; duration frozen while enabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '0;
      cfg_q.sel <= WDR_SEL_RESET;
    end else begin
      if (wr_lo && avs_address == WDR_IDX_DURATION && !en_q) begin
        cfg_q.sel <= avs_writedata[2:0];
      end
      if (wr_lo && avs_address == WDR_IDX_SPEED) begin
        cfg_q.wdt_double_speed <= avs_writedata[WDR_SPEED_WDT_BIT];
        cfg_q.core_double_speed <= avs_writedata[WDR_SPEED_CORE_BIT];
      end
    end
  end

  // Wake pin synchroniser and post-wake hold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= ext_wake_int_n;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_hold_q <= 1'b0;
    end else if (power_down) begin
      wake_hold_q <= 1'b1;
    end else if (sync2_q) begin
      wake_hold_q <= 1'b0;
    end
  end

  assign hold = power_down | wake_hold_q;

  // Machine-cycle prescaler
  assign mc_div = (cfg_q.wdt_double_speed & cfg_q.core_double_speed)
                  ? 4'(WDR_MC_DIV * 2) : 4'(WDR_MC_DIV);
  assign tick = en_q && !hold && pre_q == mc_div - 4'h1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 4'h0;
    end else if (!en_q || arm || tick) begin
      pre_q <= 4'h0;
    end else if (!hold) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Two-stage counter; overflow at the selected limit, never while held
  assign count = {prog_q, base_q};
  assign prog_lim = PROG_W'((1 << cfg_q.sel) - 1);
  assign limit = {prog_lim, {BASE_W{1'b1}}};
  assign ovf = en_q && !hold && count == limit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= '0;
      prog_q <= '0;
    end else if (arm || ovf) begin
      base_q <= '0;
      prog_q <= '0;
    end else if (tick) begin
      base_q <= base_q + 1'b1;
      if (&base_q) begin
        prog_q <= prog_q + 1'b1;
      end
    end
  end

  // Reset pulse generator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_q <= 7'h00;
    end else if (ovf) begin
      pulse_q <= 7'(WDR_RST_PULSE_CYC);
    end else if (pulse_q != 7'h00) begin
      pulse_q <= pulse_q - 7'h01;
    end
  end

  assign wdt_reset_pulse = pulse_q != 7'h00;

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr_lo && avs_address == WDR_IDX_IRQ_STATUS) begin
        status_q <= (status_q & ~avs_writedata[WDR_EV_W-1:0]) | {abort, ovf};
      end else begin
        status_q <= status_q | {abort, ovf};
      end
      if (wr_lo && avs_address == WDR_IDX_IRQ_MASK) begin
        mask_q <= avs_writedata[WDR_EV_W-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data
  assign state.enabled = en_q;
  assign state.pulse = wdt_reset_pulse;
  assign state.hold = hold;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      case (avs_address)
        WDR_IDX_RESTART: rdata_q <= 32'(WDR_RESTART_READ);
        WDR_IDX_DURATION: rdata_q <= 32'(cfg_q.sel);
        WDR_IDX_SPEED: rdata_q <= 32'({cfg_q.core_double_speed, cfg_q.wdt_double_speed});
        WDR_IDX_IRQ_STATUS: rdata_q <= 32'(status_q);
        WDR_IDX_IRQ_MASK: rdata_q <= 32'(mask_q);
        WDR_IDX_STATE: rdata_q <= 32'({state.hold, state.pulse, state.enabled});
        WDR_IDX_COUNT: rdata_q <= 32'(count);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // Checks
  logic [7:0] plen_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      plen_q <= 8'h00;
    end else if (wdt_reset_pulse) begin
      plen_q <= plen_q + 8'h01;
    end else begin
      plen_q <= 8'h00;
    end
  end

  sequence s_first_byte;
    pend_q && !abort;
  endsequence

  sequence s_second_byte;
    arm ##1 en_q && count == '0;
  endsequence

  a_arm_needs_pair: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(en_q) |-> $past(arm))
    else $error("watchdog enabled without unlock pair");

  a_pair_restarts: assert property (@(posedge clk) disable iff (sys_rst)
    s_first_byte ##0 arm |-> s_second_byte)
    else $error("unlock pair did not clear counter");

  a_abort_discards: assert property (@(posedge clk) disable iff (sys_rst)
    abort |=> !pend_q && !arm)
    else $error("broken unlock sequence kept pending");

  a_idle_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    !en_q && !$past(en_q) |-> count == '0 && !ovf)
    else $error("disabled watchdog counts");

  a_count_steps: assert property (@(posedge clk) disable iff (sys_rst)
    tick && !ovf && !arm |=> count == $past(count) + 1'b1)
    else $error("count did not step on machine cycle");

  a_stays_enabled: assert property (@(posedge clk) disable iff (sys_rst)
    en_q && !ovf |=> en_q)
    else $error("watchdog disabled without overflow");

  a_pulse_length: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(wdt_reset_pulse) |-> plen_q == 8'(WDR_RST_PULSE_CYC))
    else $error("reset pulse length wrong");

  a_ovf_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    ovf |=> wdt_reset_pulse[*8])
    else $error("overflow gave no reset pulse");

  a_sel_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    en_q |=> $stable(cfg_q.sel))
    else $error("duration changed while enabled");

  a_ovf_at_limit: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wdt_reset_pulse) |-> $past(count) == $past(limit))
    else $error("overflow away from selected limit");

  a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    tick && !cfg_q.wdt_double_speed |=> !tick[*5])
    else $error("machine cycle shorter than prescale");

  a_hold_stops: assert property (@(posedge clk) disable iff (sys_rst)
    power_down && !arm |=> $stable(count) && !wdt_reset_pulse || $past(wdt_reset_pulse))
    else $error("count moved in power-down");

  a_wake_waits: assert property (@(posedge clk) disable iff (sys_rst)
    wake_hold_q && !sync2_q |-> !tick)
    else $error("count resumed before wake pin high");

  a_disabled_still: assert property (@(posedge clk) disable iff (sys_rst)
    !en_q |-> !tick && !ovf)
    else $error("disabled watchdog ticked");

  a_ovf_disables: assert property (@(posedge clk) disable iff (sys_rst)
    ovf |=> !en_q && count == '0)
    else $error("overflow left watchdog running");

  a_timeout_event: assert property (@(posedge clk) disable iff (sys_rst)
    ovf |=> status_q[WDR_EV_TIMEOUT])
    else $error("overflow did not set timeout status");

  a_abort_event: assert property (@(posedge clk) disable iff (sys_rst)
    abort |=> status_q[WDR_EV_ABORT])
    else $error("broken unlock did not set abort status");
endmodule

// ### core/wdr_pkg.sv
/*
  Constants, register map and carrier types of the watchdog block.
  Assumes a 100 MHz core oscillator clock shared by the whole block.
*/
package wdr_pkg;
  // Register word indices on the slave bus
  localparam logic [2:0] WDR_IDX_RESTART = 3'h0;
  localparam logic [2:0] WDR_IDX_DURATION = 3'h1;
  localparam logic [2:0] WDR_IDX_SPEED = 3'h2;
  localparam logic [2:0] WDR_IDX_IRQ_STATUS = 3'h3;
  localparam logic [2:0] WDR_IDX_IRQ_MASK = 3'h4;
  localparam logic [2:0] WDR_IDX_STATE = 3'h5;
  localparam logic [2:0] WDR_IDX_COUNT = 3'h6;

  // Unlock pair and register reset values
  localparam logic [7:0] WDR_UNLOCK_FIRST = 8'h1E;
  localparam logic [7:0] WDR_UNLOCK_SECOND = 8'hE1;
  localparam logic [7:0] WDR_RESTART_READ = 8'hFF;
  localparam logic [2:0] WDR_SEL_RESET = 3'h0;

  // Field positions
  localparam int WDR_SPEED_WDT_BIT = 0;
  localparam int WDR_SPEED_CORE_BIT = 1;
  localparam int WDR_EV_TIMEOUT = 0;
  localparam int WDR_EV_ABORT = 1;
  localparam int WDR_EV_W = 2;
  localparam int WDR_STATE_EN_BIT = 0;
  localparam int WDR_STATE_PULSE_BIT = 1;
  localparam int WDR_STATE_HOLD_BIT = 2;

  // Timing
  localparam int WDR_CLK_PERIOD_NS = 10;
  localparam int WDR_RST_PULSE_TOSC = 96;
  localparam int WDR_RST_PULSE_NS = WDR_RST_PULSE_TOSC * WDR_CLK_PERIOD_NS;
  localparam int WDR_RST_PULSE_CYC = (WDR_RST_PULSE_NS + WDR_CLK_PERIOD_NS - 1)
                                     / WDR_CLK_PERIOD_NS;
  localparam int WDR_MC_DIV = 6;

  typedef struct packed {
    logic wdt_double_speed;
    logic core_double_speed;
    logic [2:0] sel;
  } wdr_cfg_s;

  typedef struct packed {
    logic enabled;
    logic pulse;
    logic hold;
  } wdr_state_s;
endpackage

// ### test/wdr_tb.sv
/*
  Self-checking bench for the watchdog block: register reset values, unlock
  pairing, every duration selection, restart, power-down hold and mid-run reset.
  Assumes the design is built with a shortened base stage to keep the run brief.
*/
`timescale 1ns/100ps
module tb;
  import wdr_pkg::*;
  // Short base stage keeps every timeout under a few thousand cycles
  localparam int BW = 2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wdt_reset_pulse;
  logic irq;
  logic power_down = 1'b0;
  logic ext_wake_int_n = 1'b1;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int arm_cyc = 0;
  int hi_cnt = 0;
  int seed_val;
  logic [31:0] rd_q[$];
  int pulse_q[$];

  wdr_watchdog #(.BASE_W(BW), .PROG_W(7)) DUT (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .power_down(power_down), .ext_wake_int_n(ext_wake_int_n),
    .wdt_reset_pulse(wdt_reset_pulse), .irq(irq));

  always #5 clk = ~clk;

  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Request held until the rising edge that samples waitrequest low, released there
  task automatic bus(input logic is_rd, input logic [2:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_read <= is_rd;
    avs_write <= !is_rd;
    avs_address <= idx;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      err_count++;
      conclude();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b1, idx, 32'h0);
  endtask

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    bus(1'b0, idx, d);
  endtask

  task automatic arm;
    wr(WDR_IDX_RESTART, 32'h1E);
    wr(WDR_IDX_RESTART, 32'hE1);
    arm_cyc = cyc;
  endtask

  // Waits for the pulse and checks its start against the expected cycle count
  task automatic wait_rise(input int exp_cyc, input int slack);
    int n;
    int dt;
    pulse_q.push_back(96);
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      if (wdt_reset_pulse === 1'b1) break;
    end
    if (n == 20000) begin
      err_count++;
      conclude();
    end
    dt = cyc - arm_cyc;
    check("timeout cycles", 32'(dt >= exp_cyc - 2 && dt <= exp_cyc + slack), 32'h1);
    repeat (100) @(negedge clk);
  endtask

  // Monitor: read data and pulse lengths against the oldest note
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata, rd_q.pop_front());
    end
    if (wdt_reset_pulse === 1'b1) begin
      hi_cnt++;
    end else if (hi_cnt > 0) begin
      if (pulse_q.size() == 0) check("unexpected pulse", 32'h1, 32'h0);
      else check("pulse length", 32'(hi_cnt), 32'(pulse_q.pop_front()));
      hi_cnt = 0;
    end
  end

  initial begin
    int s;
    int sp;
    int m;
    int lim;
    seed_val = $urandom(43110);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(WDR_IDX_DURATION, 32'h0);
    rd(WDR_IDX_SPEED, 32'h0);
    rd(WDR_IDX_IRQ_STATUS, 32'h0);
    rd(WDR_IDX_IRQ_MASK, 32'h0);
    rd(WDR_IDX_STATE, 32'h0);
    rd(WDR_IDX_RESTART, 32'hFF);
    rd(3'h7, 32'h0);
    repeat (300) @(posedge clk);
    rd(WDR_IDX_COUNT, 32'h0);
    $display("Reset values test done");
    wr(WDR_IDX_RESTART, 32'h1E);
    rd(WDR_IDX_STATE, 32'h0);
    wr(WDR_IDX_RESTART, 32'hE1);
    rd(WDR_IDX_STATE, 32'h0);
    wr(WDR_IDX_RESTART, 32'h1E);
    wr(WDR_IDX_RESTART, 32'($urandom_range(32'hDF, 32'h20)));
    wr(WDR_IDX_RESTART, 32'hE1);
    rd(WDR_IDX_STATE, 32'h0);
    rd(WDR_IDX_IRQ_STATUS, 32'h2);
    wr(WDR_IDX_IRQ_STATUS, 32'h2);
    rd(WDR_IDX_IRQ_STATUS, 32'h0);
    $display("Broken unlock test done");
    for (s = 0; s < 8; s++) begin
      // One pass always runs both double-speed bits so the doubled cycle is covered
      sp = (s == 1) ? 3 : $urandom_range(3);
      m = (sp == 3) ? 12 : 6;
      lim = (1 << (BW + s)) - 1;
      wr(WDR_IDX_SPEED, 32'(sp));
      wr(WDR_IDX_DURATION, 32'(s));
      wr(WDR_IDX_IRQ_MASK, 32'(s % 2));
      arm();
      // Selection zero is too short to fit extra bus traffic before overflow
      if (s > 0) begin
        wr(WDR_IDX_DURATION, 32'(7 - s));
        rd(WDR_IDX_DURATION, 32'(s));
        wr(WDR_IDX_STATE, 32'h0);
        wr(WDR_IDX_RESTART, 32'h0);
        rd(WDR_IDX_STATE, 32'h1);
      end
      wait_rise(lim * m, 4);
      rd(WDR_IDX_STATE, 32'h0);
      rd(WDR_IDX_IRQ_STATUS, 32'h1);
      @(negedge clk);
      check("irq", 32'(irq), 32'(s % 2));
      wr(WDR_IDX_IRQ_STATUS, 32'h1);
      @(negedge clk);
      check("irq cleared", 32'(irq), 32'h0);
    end
    $display("Duration selection test done");
    wr(WDR_IDX_SPEED, 32'h0);
    wr(WDR_IDX_DURATION, 32'h3);
    arm();
    repeat (100) @(posedge clk);
    arm();
    wait_rise(31 * 6, 4);
    $display("Restart test done");
    arm();
    repeat (50) @(posedge clk);
    power_down <= 1'b1;
    // The wake pin falls while still powered down, as a real wake interrupt does
    repeat (290) @(posedge clk);
    ext_wake_int_n <= 1'b0;
    repeat (10) @(posedge clk);
    power_down <= 1'b0;
    repeat (40) @(posedge clk);
    ext_wake_int_n <= 1'b1;
    // Held 300 powered-down cycles, 40 with the pin low, plus synchroniser latency
    wait_rise(31 * 6 + 340, 8);
    $display("Power-down hold test done");
    arm();
    repeat (20) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(WDR_IDX_STATE, 32'h0);
    repeat (400) @(posedge clk);
    rd(WDR_IDX_COUNT, 32'h0);
    $display("Mid-run reset test done");
    conclude();
  end
endmodule
